// *** pbs_burst_order.sv ***
// Burst order mapping of the two low address bits
`timescale 1ns/100ps
`default_nettype none
`include "pbs_consts.svh"

module pbs_burst_order (
   input  wire logic [`PBS_BURST_LO_W-1:0] start_in,
   input  wire logic [`PBS_BURST_LO_W-1:0] count_in,
   input  wire logic                       linear_order_sel_n_in,
   output logic      [`PBS_BURST_LO_W-1:0] addr_lo_out
);

   // High selects interleaved (xor), low selects linear (modulo add)
   always_comb begin
      if (linear_order_sel_n_in) begin
         addr_lo_out = start_in ^ count_in;
      end else begin
         addr_lo_out = start_in + count_in;
      end
   end

endmodule // pbs_burst_order
`default_nettype wire

// *** pbs_consts.svh ***
// Constants for the pipelined burst SRAM block
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

`define PBS_DATA_W       32
`define PBS_ADDR_W       15
`define PBS_LANES        4
`define PBS_LANE_W       8
`define PBS_BURST_LO_W   2
`define PBS_CNT_RST      2'h0
`define PBS_CNT_LAST     2'h3
`define PBS_CNT_STEP     2'h1
`define PBS_LANES_ALL    4'hf
`define PBS_LANES_NONE   4'h0
`define PBS_DOUT_RST     32'h0000_0000

`endif

// *** pbs_host_model.sv ***
// Host-side model of the processor or cache controller driving burst cycles
`timescale 1ns/100ps
`default_nettype none
module pbs_host_model (
   input  wire logic        clk_in,
   output logic      [7:0]  ctl_out,
   output logic      [14:0] addr_out,
   output logic      [3:0]  lanes_out,
   output logic      [31:0] dq_out
);
   // Idle: deselected through the controller strobe with chip enable off
   initial begin
      ctl_out = 8'hd7;
      addr_out = 15'h0000;
      lanes_out = 4'hf;
      dq_out = 32'h0000_0000;
   end
   // One cycle off the falling edge; released data toggles every cycle
   task automatic cyc(input logic [7:0] c, input logic [14:0] a, input logic [3:0] l,
                      input logic [31:0] d);
      @(negedge clk_in);
      ctl_out = c;
      addr_out = a;
      lanes_out = l;
      dq_out = (!c[1] || (!c[0] && l != 4'hf)) ? d : ~dq_out;
   endtask
endmodule // pbs_host_model
`default_nettype wire

// *** pbs_pkg.sv ***
// Types for the pipelined burst SRAM block
`default_nettype none
package pbs_pkg;

   // Kind of synchronous cycle decoded on a rising edge
   typedef enum logic [4:0] {
      PBS_CYC_SLEEP = 5'b00001,
      PBS_CYC_DESEL = 5'b00010,
      PBS_CYC_LOAD  = 5'b00100,
      PBS_CYC_STEP  = 5'b01000,
      PBS_CYC_HOLD  = 5'b10000
   } pbs_cyc_t;

endpackage
`default_nettype wire

// *** pbs_sram_ctrl.sv ***
// Pipelined burst SRAM: cycle decode, burst counter, array and data pipeline
//
// Notes on behaviour
// [R1] Deselect and float data when enable off with controller strobe, or selects off.
// [R2] Selected with processor strobe low: load address, read; controller strobe too if no write.
// [R3] Write burst starts from external address via controller strobe with a write request.
// [R4] No load and step low: advance burst address and read.
// [R5] No load and step low with a write request: write at next burst address.
// [R6] No load and step high: read at the current address.
// [R7] No load and step high with a write request: write at the current address.
// [R8] All-byte write writes four lanes; else gated lane selects choose lanes.
// [R9] Any mix of lane selects may be low; every selected lane is written.
// [R10] Output enable acts asynchronously; writes and deselects keep pins floating.
// [R11] Cycle decoding acts only while sleep is low; sleep defaults low.
// [R12] Qualified processor strobe blocks byte writes; processor strobe is ignored while chip enable is off.
// [R13] Order select high is interleaved, low linear, and must stay static.
// [R14] Burst counter runs four addresses in the chosen order, then wraps.
// [R15] Sleep stops the block, floats data pins and keeps stored data.
// [R16] Read data appears after the edge following the address edge.
// [R17] Lane select one controls bits 7:0, then ascending lanes.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_consts.svh"

module pbs_sram_ctrl #(
   parameter int ADDR_W = `PBS_ADDR_W,
   parameter int DATA_W = `PBS_DATA_W,
   parameter int LANES  = `PBS_LANES
) (
   input  wire logic              SYS_CLK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic              CHIP_EN_N_IN,
   input  wire logic              SELECT_HIGH_IN,
   input  wire logic              SELECT_LOW_N_IN,
   input  wire logic              PROC_LOAD_STROBE_N_IN,
   input  wire logic              CTRL_LOAD_STROBE_N_IN,
   input  wire logic              BURST_STEP_N_IN,
   input  wire logic              ALL_BYTE_WRITE_N_IN,
   input  wire logic              BYTE_WRITE_GATE_N_IN,
   input  wire logic [LANES-1:0]  BYTE_LANE_SELECT_N_IN,
   input  wire logic              OUT_EN_N_IN,
   input  wire logic              SLEEP_REQ_IN,
   input  wire logic              LINEAR_ORDER_SEL_N_IN,
   input  wire logic [DATA_W-1:0] DQ_IN,
   output logic      [DATA_W-1:0] DQ_OUT,
   output logic                   DQ_OE_OUT
);

   localparam int LW = `PBS_LANE_W;
   localparam int BW = `PBS_BURST_LO_W;

   // Refuse shapes the lane and burst logic cannot serve
   if (DATA_W != LANES * LW || ADDR_W <= BW) begin : g_bad_shape
      $error("pbs_sram_ctrl: DATA_W must be 8*LANES and ADDR_W above 2");
   end

   // Storage array, no reset: contents survive sleep
   logic [DATA_W-1:0] mem [(2**ADDR_W)];

   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] next_cur_addr;
   logic [BW-1:0]     start_lo;
   logic [BW-1:0]     next_start_lo;
   logic [BW-1:0]     count;
   logic [BW-1:0]     next_count;
   logic [BW-1:0]     step_count;
   logic [BW-1:0]     step_lo;
   logic              rd_pend;
   logic              next_rd_pend;
   logic              drive;
   logic              next_drive;
   logic [DATA_W-1:0] dout;
   logic [DATA_W-1:0] next_dout;
   logic [DATA_W-1:0] rd_word;

   pbs_pkg::pbs_cyc_t cyc;
   logic              sel;
   logic              desel;
   logic              proc_load;
   logic              ctrl_load;
   logic              no_load;
   logic              wr_req;
   logic [LANES-1:0]  lanes;
   logic              write_now;

   // Lane enables: none with chip enable and processor strobe low, else all-byte write, else gated selects, lane 0 is bits 7:0
   always_comb begin
      if (!CHIP_EN_N_IN && !PROC_LOAD_STROBE_N_IN) begin
         lanes = `PBS_LANES_NONE;                          // see [R12]
      end else if (!ALL_BYTE_WRITE_N_IN) begin
         lanes = `PBS_LANES_ALL;                           // see [R8]
      end else if (!BYTE_WRITE_GATE_N_IN) begin
         lanes = ~BYTE_LANE_SELECT_N_IN;                   // see [R9] see [R17]
      end else begin
         lanes = `PBS_LANES_NONE;
      end
   end

   // Cycle decode: sleep first, then deselect, then address loads, then burst continue
   assign sel       = !CHIP_EN_N_IN && SELECT_HIGH_IN && !SELECT_LOW_N_IN;
   assign proc_load = sel && !PROC_LOAD_STROBE_N_IN;       // see [R12]
   assign ctrl_load = sel && !CTRL_LOAD_STROBE_N_IN;       // see [R12]
   assign desel     = (CHIP_EN_N_IN && !CTRL_LOAD_STROBE_N_IN)
                    || (!CHIP_EN_N_IN && !sel
                        && (!PROC_LOAD_STROBE_N_IN || !CTRL_LOAD_STROBE_N_IN)); // see [R1]
   assign no_load   = CTRL_LOAD_STROBE_N_IN && (PROC_LOAD_STROBE_N_IN || CHIP_EN_N_IN);
   assign wr_req    = |lanes;

   always_comb begin
      if (SLEEP_REQ_IN) begin
         cyc = pbs_pkg::PBS_CYC_SLEEP;                     // see [R11] see [R15]
      end else if (desel) begin
         cyc = pbs_pkg::PBS_CYC_DESEL;                     // see [R1]
      end else if (proc_load || ctrl_load) begin
         cyc = pbs_pkg::PBS_CYC_LOAD;                      // see [R2] see [R3]
      end else if (no_load && !BURST_STEP_N_IN) begin
         cyc = pbs_pkg::PBS_CYC_STEP;                      // see [R4] see [R5]
      end else begin
         cyc = pbs_pkg::PBS_CYC_HOLD;                      // see [R6] see [R7]
      end
   end

   // Burst count advance and its mapping onto the low address bits
   assign step_count = count + `PBS_CNT_STEP;              // see [R14]

   pbs_burst_order u_order (
      .start_in              (start_lo),
      .count_in              (step_count),
      .linear_order_sel_n_in (LINEAR_ORDER_SEL_N_IN),      // see [R13]
      .addr_lo_out           (step_lo)
   );

   // Address used this cycle and whether it writes
   always_comb begin
      next_cur_addr = cur_addr;
      next_start_lo = start_lo;
      next_count    = count;
      write_now     = 1'b0;
      unique case (cyc)
         pbs_pkg::PBS_CYC_SLEEP,
         pbs_pkg::PBS_CYC_DESEL: begin
            write_now = 1'b0;
         end
         pbs_pkg::PBS_CYC_LOAD: begin
            next_cur_addr = ADDR_IN;                       // see [R2] see [R3]
            next_start_lo = ADDR_IN[BW-1:0];
            next_count    = `PBS_CNT_RST;
            write_now     = wr_req && !proc_load;          // see [R3] see [R12]
         end
         pbs_pkg::PBS_CYC_STEP: begin
            next_cur_addr = {cur_addr[ADDR_W-1:BW], step_lo}; // see [R4] see [R14]
            next_count    = step_count;                    // see [R14]
            write_now     = wr_req;                        // see [R5]
         end
         pbs_pkg::PBS_CYC_HOLD: begin
            write_now     = wr_req;                        // see [R7]
         end
      endcase
   end

   // Read pipeline: address edge, then data edge; writes, deselects and sleep float the pins
   assign rd_word = mem[cur_addr];

   always_comb begin
      next_rd_pend = (cyc == pbs_pkg::PBS_CYC_LOAD || cyc == pbs_pkg::PBS_CYC_STEP
                      || cyc == pbs_pkg::PBS_CYC_HOLD) && !write_now; // see [R2] see [R4] see [R6]
      next_drive   = rd_pend && !write_now && !SLEEP_REQ_IN;          // see [R10] see [R16]
      next_dout    = next_drive ? rd_word : dout;                     // see [R16]
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cur_addr <= '0;
         start_lo <= `PBS_CNT_RST;
         count    <= `PBS_CNT_RST;
         rd_pend  <= 1'b0;
         drive    <= 1'b0;
         dout     <= `PBS_DOUT_RST;
      end else begin
         cur_addr <= next_cur_addr;
         start_lo <= next_start_lo;
         count    <= next_count;
         rd_pend  <= next_rd_pend;
         drive    <= next_drive;
         dout     <= next_dout;
      end
   end

   // Byte-lane writes into the array at the address of this cycle
   always_ff @(posedge SYS_CLK_IN) begin
      for (int i = 0; i < LANES; i++) begin
         if (write_now && lanes[i]) begin
            mem[next_cur_addr][i*LW +: LW] <= DQ_IN[i*LW +: LW]; // see [R8] see [R9] see [R17]
         end
      end
   end

   // Output enable and sleep act without the clock on the pin driver
   assign DQ_OUT    = dout;
   assign DQ_OE_OUT = drive && !OUT_EN_N_IN && !SLEEP_REQ_IN; // see [R10] see [R15]

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   deselect_floats_a : assert property ( // see [R1]
      (!SLEEP_REQ_IN && desel) |-> ##2 !drive)
      else $error("data pins driven after a deselect cycle");

   proc_read_a : assert property ( // see [R2]
      (!SLEEP_REQ_IN && proc_load) ##1 (!write_now && !SLEEP_REQ_IN) |=> drive)
      else $error("processor load did not produce read data");

   ctrl_write_load_a : assert property ( // see [R3]
      (cyc == pbs_pkg::PBS_CYC_LOAD && !proc_load && wr_req)
      |-> write_now ##1 (cur_addr == $past(ADDR_IN) && !rd_pend))
      else $error("controller write did not load the external address");

   burst_step_a : assert property ( // see [R4] see [R5]
      (cyc == pbs_pkg::PBS_CYC_STEP)
      |=> (count == $past(count) + 2'h1) && (cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2])))
      else $error("burst step did not advance the counter");

   burst_hold_a : assert property ( // see [R6] see [R7]
      (cyc == pbs_pkg::PBS_CYC_HOLD) |=> $stable(cur_addr) && $stable(count))
      else $error("suspended burst moved its address");

   lane_map_a : assert property ( // see [R8] see [R17]
      ((!ALL_BYTE_WRITE_N_IN && !(!CHIP_EN_N_IN && !PROC_LOAD_STROBE_N_IN))
       |-> lanes == `PBS_LANES_ALL)
      and ((ALL_BYTE_WRITE_N_IN && !BYTE_WRITE_GATE_N_IN
            && !(!CHIP_EN_N_IN && !PROC_LOAD_STROBE_N_IN))
           |-> lanes == ~BYTE_LANE_SELECT_N_IN))
      else $error("byte lane enables wrong");

   write_floats_a : assert property ( // see [R10]
      write_now |=> !DQ_OE_OUT)
      else $error("data pins driven in the cycle after a write");

   proc_blocks_write_a : assert property ( // see [R12]
      (!CHIP_EN_N_IN && !PROC_LOAD_STROBE_N_IN) |-> !write_now)
      else $error("write taken with processor strobe low");

   burst_wrap_a : assert property ( // see [R14]
      (cyc == pbs_pkg::PBS_CYC_LOAD) ##1 (cyc == pbs_pkg::PBS_CYC_STEP) [*4]
      |=> cur_addr == $past(cur_addr, 4))
      else $error("burst did not wrap to its first address");

   sleep_idle_a : assert property ( // see [R11] see [R15]
      SLEEP_REQ_IN |-> !DQ_OE_OUT ##1 ($stable(cur_addr) && !drive))
      else $error("block active during sleep");

   read_pipe_a : assert property ( // see [R16]
      (rd_pend && !write_now && !SLEEP_REQ_IN) |=> drive && DQ_OUT == $past(rd_word))
      else $error("pipelined read data wrong");

endmodule // pbs_sram_ctrl
`default_nettype wire

// *** pipelined_burst_sram_ctrl_test.sv ***
// Self-checking testbench of the pipelined burst SRAM block
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_burst_sram_ctrl;
   localparam logic [7:0] PLD = 8'h4f, PWR = 8'h4d, CWR = 8'h55, CBW = 8'h56, CRD = 8'h57;
   localparam logic [7:0] SWR = 8'h59, SRD = 8'h5b, HRD = 8'h5f, HWR = 8'h5d, DSL = 8'hd7;
   localparam logic [7:0] XBW = 8'hbe; // Chip off, no load, step high: held byte write
   localparam logic [14:0] A = 15'h0101, B = 15'h0200;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        oe_n = 1'b0;
   logic        sleep = 1'b0;
   logic        lin_n = 1'b0;
   logic [7:0]  ctl;
   logic [14:0] addr;
   logic [3:0]  lanes;
   logic [31:0] dq_w;
   logic [31:0] dq_r;
   logic        dq_oe;
   logic [31:0] mem [logic [14:0]];
   int          miscompares = 0;
   int          num_checks = 0;
   // Clock at 200 MHz
   always #2.5 clk = ~clk;
   // Block under test and the host driving it
   pbs_sram_ctrl u_dut (
      .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
      .CHIP_EN_N_IN(ctl[7]), .SELECT_HIGH_IN(ctl[6]), .SELECT_LOW_N_IN(ctl[5]),
      .PROC_LOAD_STROBE_N_IN(ctl[4]), .CTRL_LOAD_STROBE_N_IN(ctl[3]),
      .BURST_STEP_N_IN(ctl[2]), .ALL_BYTE_WRITE_N_IN(ctl[1]),
      .BYTE_WRITE_GATE_N_IN(ctl[0]), .BYTE_LANE_SELECT_N_IN(lanes),
      .OUT_EN_N_IN(oe_n), .SLEEP_REQ_IN(sleep), .LINEAR_ORDER_SEL_N_IN(lin_n),
      .DQ_IN(dq_w), .DQ_OUT(dq_r), .DQ_OE_OUT(dq_oe)
   );
   pbs_host_model host (
      .clk_in(clk), .ctl_out(ctl), .addr_out(addr), .lanes_out(lanes), .dq_out(dq_w)
   );
   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Address of burst word k from start a in the selected order
   function automatic logic [14:0] burst_addr(input logic [14:0] a, input int k);
      return {a[14:2], lin_n ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
   endfunction
   // One cycle, with the expected array updated lane by lane
   task automatic put(input logic [7:0] c, input logic [14:0] a, input logic [3:0] l,
                      input logic [31:0] d);
      host.cyc(c, a, l, d);
      for (int i = 0; i < 4; i++)
         if (!c[1] || (!c[0] && !l[i])) mem[a][8*i +: 8] = d[8*i +: 8];
   endtask
   // Burst write from a, then a held write on the last word
   task automatic wr(input logic [14:0] a, input logic [31:0] d);
      put(CWR, a, 4'hf, d);
      for (int k = 1; k < 4; k++)
         put(SWR, burst_addr(a, k), 4'hf, d + 32'(k));
      put(HWR, burst_addr(a, 3), 4'hf, ~d);
   endtask
   // Load with c0, continue with cn, check n words one cycle behind the address
   task automatic rd(input logic [7:0] c0, input logic [7:0] cn, input logic [14:0] a,
                     input int n);
      host.cyc(c0, a, 4'hf, 32'hdead_beef);
      host.cyc(cn, ~a, 4'hf, 32'h0);
      for (int k = 0; k < n; k++) begin
         host.cyc(cn, ~a, 4'hf, 32'h0);
         chk("read data", dq_r, mem[cn == HRD ? a : burst_addr(a, k)]);
         chk("drive", {31'h0, dq_oe}, 32'h1);
      end
   endtask
   // Three deselect forms: chip enable off, then select high low under each strobe, each with a write request that must be dropped
   task automatic desel();
      host.cyc(8'hd5, A, 4'h0, 32'h5a5a_5a5a);
      host.cyc(8'h15, A, 4'h0, 32'h5a5a_5a5a);
      host.cyc(8'h0d, A, 4'h0, 32'h5a5a_5a5a);
      chk("drive", {31'h0, dq_oe}, 32'h0);
   endtask
   // Single lanes, a lane mix and the two no-write cases, then read back
   task automatic lanes_test();
      wr(B, 32'h0);
      for (int i = 0; i < 4; i++)
         put(CBW, B + 15'(i), ~(4'h1 << i), 32'hc3c3_c3c3);
      put(CBW, B, 4'b1010, 32'ha5a5_a5a5);
      put(CBW, B + 15'h1, 4'hf, 32'h7777_7777);
      put(CRD, B + 15'h2, 4'h0, 32'h0);
      put(XBW, B + 15'h2, 4'b0110, 32'h9696_9696);
      rd(PLD, SRD, B, 4);
   endtask
   // Output enable, sleep with dropped writes, wake behind a deselect, retention
   task automatic nap();
      rd(PLD, HRD, A, 1);
      @(negedge clk);
      oe_n = 1'b1;
      #1;
      chk("drive", {31'h0, dq_oe}, 32'h0);
      @(negedge clk);
      oe_n = 1'b0;
      #1;
      chk("drive", {31'h0, dq_oe}, 32'h1);
      chk("held read data", dq_r, mem[A]);
      @(negedge clk);
      sleep = 1'b1;
      #1;
      chk("drive", {31'h0, dq_oe}, 32'h0);
      // Writes offered while asleep are dropped; the wake edge must see a deselect
      repeat (20) host.cyc(CWR, A, 4'h0, 32'h1234_5678);
      host.cyc(DSL, A, 4'hf, 32'h0);
      sleep = 1'b0;
      repeat (20) host.cyc(DSL, A, 4'hf, 32'h0);
      chk("drive", {31'h0, dq_oe}, 32'h0);
      rd(PLD, SRD, A, 4);
   endtask
   // Burst write, then a burst read that runs past the wrap
   task automatic burst_test();
      wr(A, 32'h1000_0001);
      rd(PLD, SRD, A, 5);
   endtask
   // Controller-strobe read, and a processor load whose all-byte write is dropped
   task automatic load_test();
      rd(CRD, SRD, A, 4);
      rd(PWR, HRD, A, 2);
   endtask
   // Order select changes only while held in reset, then an interleaved burst
   task automatic order_test();
      @(negedge clk);
      rst_n = 1'b0;
      lin_n = 1'b1;
      #1;
      chk("reset data", dq_r, 32'h0);
      chk("drive", {31'h0, dq_oe}, 32'h0);
      repeat (6) host.cyc(DSL, A, 4'hf, 32'h0);
      rst_n = 1'b1;
      rd(PLD, SRD, A, 5);
   endtask
   // Counts and verdict
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("reset data", dq_r, 32'h0);
      chk("drive", {31'h0, dq_oe}, 32'h0);
      rst_n = 1'b1;
      burst_test();
      desel();
      load_test();
      lanes_test();
      nap();
      order_test();
      summarize();
   end
endmodule // test_pipelined_burst_sram_ctrl
`default_nettype wire
